// ==== hdl/twic_pkg.sv ====
// constants and types shared by the two-wire host controller
package twic_pkg;
	// register indexes, byte address is four times the index
	localparam logic [9:0] IDX_LINE  = 10'h000;
	localparam logic [9:0] IDX_DEBUG = 10'h002;
	localparam logic [9:0] IDX_SETUP = 10'h003;
	localparam logic [9:0] IDX_CMD   = 10'h004;
	localparam logic [9:0] IDX_FLAGS = 10'h005;
	localparam logic [9:0] IDX_ADDR  = 10'h007;
	localparam logic [9:0] IDX_DATA  = 10'h008;
	// field positions
	localparam int B_SETUP_SEL = 4;
	localparam int B_HOLD_LSB  = 2;
	localparam int B_FAST_PLUS = 1;
	localparam int B_DBG_RUN   = 0;
	localparam int B_RD_IEN    = 7;
	localparam int B_WR_IEN    = 6;
	localparam int B_QUICK     = 4;
	localparam int B_TMO_LSB   = 2;
	localparam int B_SMART     = 1;
	localparam int B_ENABLE    = 0;
	localparam int B_FLUSH     = 3;
	localparam int B_ACK       = 2;
	localparam int B_RDONE     = 7;
	localparam int B_WDONE     = 6;
	localparam int B_SCLHOLD   = 5;
	localparam int B_ARB       = 3;
	localparam int B_BERR      = 2;
	// writable bits and reset values
	localparam logic [7:0] LINE_MASK  = 8'h1e;
	localparam logic [7:0] SETUP_MASK = 8'hdf;
	localparam logic [7:0] RST_LINE   = 8'h00;
	localparam logic [7:0] RST_SETUP  = 8'h00;
	localparam logic [7:0] RST_ADDR   = 8'h00;
	localparam logic [7:0] RST_DATA   = 8'h00;
	// timing at a 25 ns clock
	localparam int TW     = 14;
	localparam int CLK_NS = 25;
	localparam logic [TW-1:0] SETUP_SHORT_CYC = 14'h0004;
	localparam logic [TW-1:0] SETUP_LONG_CYC  = 14'h0008;
	localparam int HOLD1_NS    = 50;
	localparam int HOLD2_NS    = 300;
	localparam int HOLD3_NS    = 500;
	localparam int STD_HALF_NS = 5000;
	localparam int FMP_HALF_NS = 500;
	localparam logic [TW-1:0] HOLD1_CYC = TW'((HOLD1_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [TW-1:0] HOLD2_CYC = TW'((HOLD2_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [TW-1:0] HOLD3_CYC = TW'((HOLD3_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [TW-1:0] STD_HALF_CYC = TW'(STD_HALF_NS / CLK_NS);
	localparam logic [TW-1:0] FMP_HALF_CYC = TW'(FMP_HALF_NS / CLK_NS);
	localparam int TMO1_US    = 50;
	localparam int TMO2_US    = 100;
	localparam int TMO3_US    = 200;
	localparam int CYC_PER_US = 1000 / CLK_NS;
	localparam logic [TW-1:0] TMO1_CYC = TW'(TMO1_US * CYC_PER_US);
	localparam logic [TW-1:0] TMO2_CYC = TW'(TMO2_US * CYC_PER_US);
	localparam logic [TW-1:0] TMO3_CYC = TW'(TMO3_US * CYC_PER_US);
	typedef enum logic [1:0] {
		op_none      = 2'h0,
		op_restart   = 2'h1,
		op_next_byte = 2'h2,
		op_stop      = 2'h3
	} twic_op_type;
	typedef enum logic [1:0] {
		LS_UNKNOWN = 2'h0,
		LS_IDLE    = 2'h1,
		LS_OWNER   = 2'h2,
		LS_BUSY    = 2'h3
	} twic_line_type;
endpackage

// ==== hdl/twic_sync.sv ====
// two-flop synchroniser for the bus lines
`timescale 1ns/1ps
module twic_sync #(
	parameter int unsigned W = 2
) (
	// clock, reset and freeze
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         ce,
	// lines
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	import twic_pkg::*;

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] safe;
	} twic_sync_type;

	twic_sync_type r;
	twic_sync_type n;

	always_comb begin
		n      = r;
		n.meta = async_in;
		n.safe = r.meta;
	end

	// idle bus lines are high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '1;
		end else if (ce) begin
			r <= n;
		end
	end

	assign sync_out = r.safe;
endmodule

// ==== hdl/twic_count.sv ====
// loadable down counter used for bit phases and the idle timeout
`timescale 1ns/1ps
module twic_count (
	// clock, reset and freeze
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   ce,
	// control
	input  wire logic                   load,
	input  wire logic [twic_pkg::TW-1:0] load_val,
	input  wire logic                   run,
	// status
	output logic      [twic_pkg::TW-1:0] remain,
	output logic                        zero
);
	import twic_pkg::*;

	typedef struct packed {
		logic [TW-1:0] cnt;
	} twic_count_type;

	twic_count_type r;
	twic_count_type n;

	always_comb begin
		n = r;
		if (load) begin
			n.cnt = load_val;
		end else if (run && r.cnt != '0) begin
			n.cnt = r.cnt - 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
		end else if (ce) begin
			r <= n;
		end
	end

	assign remain = r.cnt;
	assign zero   = (r.cnt == '0);
endmodule

// ==== hdl/twic_host.sv ====
// two-wire bus host controller with apb register access
`timescale 1ns/1ps
module twic_host #(
	parameter logic [twic_pkg::TW-1:0] P_TMO1_CYC = twic_pkg::TMO1_CYC,
	parameter logic [twic_pkg::TW-1:0] P_TMO2_CYC = twic_pkg::TMO2_CYC,
	parameter logic [twic_pkg::TW-1:0] P_TMO3_CYC = twic_pkg::TMO3_CYC
) (
	// clock, reset and freeze
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// processor context, same clock
	input  wire logic        debug_halt,
	input  wire logic        global_irq_enable,
	// open-drain bus pins
	input  wire logic        scl_in,
	output logic             scl_out,
	output logic             scl_oe_n,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_n,
	// interrupt requests
	output logic             read_irq,
	output logic             write_irq
);
	import twic_pkg::*;

	typedef enum logic [9:0] {
		ST_IDLE  = 10'h001,
		ST_START = 10'h002,
		ST_LOW   = 10'h004,
		ST_HIGH  = 10'h008,
		ST_HOLD  = 10'h010,
		ST_RS1   = 10'h020,
		ST_RS2   = 10'h040,
		ST_SP1   = 10'h080,
		ST_SP2   = 10'h100,
		ST_SP3   = 10'h200
	} twic_st_type;

	typedef struct packed {
		logic [7:0]    line_ctl;
		logic          run_dbg;
		logic [7:0]    setup;
		logic          ack;
		logic          flush;
		logic          read_done_flag;
		logic          write_done_flag;
		logic          hold;
		logic          last_received_acknowledge;
		logic          arb;
		logic          berr;
		twic_line_type lstate;
		logic [7:0]    addr;
		logic [7:0]    data;
		logic [7:0]    sh;
		twic_st_type   st;
		logic [3:0]    bitn;
		logic          rx;
		logic          addr_ph;
		logic          ack_only;
		logic          pend;
		twic_op_type   post;
		logic [1:0]    prev;
		logic          scl_oe_n;
		logic          sda_oe_n;
		logic          pin_lvl;
		logic [31:0]   prdata;
		logic          pready;
		logic          pslverr;
		logic          read_irq;
		logic          write_irq;
	} twic_core_type;

	twic_core_type r;
	twic_core_type n;
	logic [1:0]    lines;
	logic [TW-1:0] t_remain;
	logic          t_zero;
	logic          tload;
	logic [TW-1:0] tval;
	logic          to_zero;
	logic          to_load;
	logic [TW-1:0] to_val;
	logic          acc;
	logic          hit;
	logic [7:0]    rdv;
	logic [7:0]    w;
	logic          wr_line;
	logic          wr_dbg;
	logic          wr_setup;
	logic          wr_cmd;
	logic          wr_flags;
	logic          wr_addr;
	logic          wr_data;
	logic          rd_data;
	logic          cmd_ok;
	logic          clr;
	logic          go;
	logic          stretch;
	logic          drv;
	logic          lost;
	logic          st_det;
	logic          sp_det;
	logic [TW-1:0] half;
	logic [TW-1:0] setc;
	logic [TW-1:0] holdc;
	logic [TW-1:0] low_len;

	twic_sync #(
		.W (2)
	) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.ce       (ce),
		.async_in ({scl_in, sda_in}),
		.sync_out (lines)
	);

	twic_count u_phase (
		.pclk     (pclk),
		.presetn  (presetn),
		.ce       (ce),
		.load     (tload),
		.load_val (tval),
		.run      (go),
		.remain   (t_remain),
		.zero     (t_zero)
	);

	twic_count u_idle (
		.pclk     (pclk),
		.presetn  (presetn),
		.ce       (ce),
		.load     (to_load),
		.load_val (to_val),
		.run      (r.setup[B_ENABLE]),
		.remain   (),
		.zero     (to_zero)
	);

	// ack action of one bit, then the follow-up operation
	function automatic twic_core_type ack_then(input twic_core_type s, input twic_op_type op);
		s.st       = ST_LOW;
		s.bitn     = 4'd8;
		s.ack_only = 1'b1;
		s.post     = op;
		s.hold     = 1'b0;
		return s;
	endfunction

	// scl is low whenever an operation is launched
	function automatic twic_core_type launch(input twic_core_type s, input twic_op_type op);
		s.hold = 1'b0;
		unique case (op)
			op_none: begin
				s.st   = ST_HOLD;
				s.hold = 1'b1;
			end
			op_restart: begin
				s.st       = ST_RS1;
				s.sda_oe_n = 1'b1;
			end
			op_next_byte: begin
				s.st   = ST_LOW;
				s.rx   = 1'b1;
				s.bitn = 4'd0;
			end
			op_stop: begin
				s.st       = ST_SP1;
				s.sda_oe_n = 1'b0;
			end
		endcase
		return s;
	endfunction

	always_comb begin
		n       = r;
		stretch = 1'b0;
		lost    = 1'b0;
		w       = pwdata[7:0];
		acc     = psel & penable & r.pready;
		hit     = 1'b1;
		unique case (paddr[11:2])
			IDX_LINE:  rdv = r.line_ctl;
			IDX_DEBUG: rdv = {7'h00, r.run_dbg};
			IDX_SETUP: rdv = r.setup;
			IDX_CMD:   rdv = {5'h00, r.ack, 2'h0};
			IDX_FLAGS: rdv = {r.read_done_flag, r.write_done_flag, r.hold, r.last_received_acknowledge, r.arb, r.berr, r.lstate};
			IDX_ADDR:  rdv = r.addr;
			IDX_DATA:  rdv = r.data;
			default: begin
				rdv = 8'h00;
				hit = 1'b0;
			end
		endcase
		wr_line  = acc & pwrite & (paddr[11:2] == IDX_LINE);
		wr_dbg   = acc & pwrite & (paddr[11:2] == IDX_DEBUG);
		wr_setup = acc & pwrite & (paddr[11:2] == IDX_SETUP);
		wr_cmd   = acc & pwrite & (paddr[11:2] == IDX_CMD);
		wr_flags = acc & pwrite & (paddr[11:2] == IDX_FLAGS);
		wr_addr  = acc & pwrite & (paddr[11:2] == IDX_ADDR);
		wr_data  = acc & pwrite & (paddr[11:2] == IDX_DATA);
		rd_data  = acc & !pwrite & (paddr[11:2] == IDX_DATA);
		cmd_ok   = wr_cmd & (w[1:0] != op_none);
		go       = r.setup[B_ENABLE] & (!debug_halt | r.run_dbg);
		half     = r.line_ctl[B_FAST_PLUS] ? FMP_HALF_CYC : STD_HALF_CYC;
		setc     = r.line_ctl[B_SETUP_SEL] ? SETUP_LONG_CYC : SETUP_SHORT_CYC;
		unique case (r.line_ctl[B_HOLD_LSB +: 2])
			2'h0: holdc = '0;
			2'h1: holdc = HOLD1_CYC;
			2'h2: holdc = HOLD2_CYC;
			2'h3: holdc = HOLD3_CYC;
		endcase
		// low phase stretches when hold plus setup exceed half a period
		low_len = (half > holdc + setc) ? half : holdc + setc;
		drv     = (r.bitn == 4'd8) ? (r.ack_only ? r.ack : 1'b1) : (r.rx ? 1'b1 : r.sh[7]);
		st_det  = r.prev[1] & lines[1] & r.prev[0] & !lines[0];
		sp_det  = r.prev[1] & lines[1] & !r.prev[0] & lines[0];
		n.prev  = lines;

		// apb: answer one cycle after setup, data captured at setup
		n.pready = psel & !penable;
		if (psel & !penable) begin
			n.prdata  = {24'h000000, rdv};
			n.pslverr = !hit;
		end

		// software clears come first so that hardware sets win
		clr = wr_addr | wr_data | cmd_ok | rd_data;
		if (clr | (wr_flags & w[B_RDONE])) n.read_done_flag = 1'b0;
		if (clr | (wr_flags & w[B_WDONE])) n.write_done_flag = 1'b0;
		if (clr | (wr_flags & w[B_SCLHOLD])) n.hold = 1'b0;
		if (clr | (wr_flags & w[B_ARB])) n.arb = 1'b0;
		if (clr | (wr_flags & w[B_BERR])) n.berr = 1'b0;
		if (wr_flags & (w[1:0] == LS_IDLE) & r.setup[B_ENABLE]) n.lstate = LS_IDLE;
		if (wr_line) n.line_ctl = w & LINE_MASK;
		if (wr_dbg) n.run_dbg = w[B_DBG_RUN];
		if (wr_setup) n.setup = w & SETUP_MASK;
		if (wr_cmd) n.ack = w[B_ACK];
		n.flush = wr_cmd & w[B_FLUSH];
		if (wr_addr) n.addr = w;
		if (wr_data) n.data = w;

		if (!r.setup[B_ENABLE] | r.flush) begin
			// disabled or flushed: bus released, position forgotten
			n.st       = ST_IDLE;
			n.scl_oe_n = 1'b1;
			n.sda_oe_n = 1'b1;
			n.pend     = 1'b0;
			n.ack_only = 1'b0;
			n.hold     = 1'b0;
			n.lstate   = LS_UNKNOWN;
			if (r.flush) begin
				n.addr = RST_ADDR;
				n.data = RST_DATA;
			end
		end else if (go) begin
			if (wr_addr) begin
				if (r.st == ST_HOLD) begin
					// repeated start, ack action first after a read
					if (r.rx) n = ack_then(n, op_restart);
					else n = launch(n, op_restart);
				end else if (r.st == ST_IDLE) begin
					if (r.lstate == LS_UNKNOWN) begin
						n.write_done_flag  = 1'b1;
						n.berr = 1'b1;
					end else begin
						n.pend = 1'b1;
					end
				end
			end
			if (wr_data && r.st == ST_HOLD && !r.rx) begin
				n.sh   = w;
				n.bitn = 4'd0;
				n.st   = ST_LOW;
			end
			if (rd_data && r.st == ST_HOLD && r.rx && r.setup[B_SMART] && !r.ack) begin
				n = ack_then(n, op_next_byte);
			end
			if (cmd_ok && r.st == ST_HOLD) begin
				if (r.rx) n = ack_then(n, twic_op_type'(w[1:0]));
				else if (w[1:0] != op_next_byte) n = launch(n, twic_op_type'(w[1:0]));
			end

			unique case (r.st)
				ST_IDLE: if (r.pend && r.lstate == LS_IDLE) begin
					n.st       = ST_START;
					n.sda_oe_n = 1'b0;
					n.pend     = 1'b0;
					n.lstate   = LS_OWNER;
				end
				ST_START: if (t_zero) begin
					n.scl_oe_n = 1'b0;
					n.st       = ST_LOW;
					n.sh       = r.addr;
					n.bitn     = 4'd0;
					n.rx       = 1'b0;
					n.addr_ph  = 1'b1;
					n.ack_only = 1'b0;
				end
				ST_LOW: begin
					if (t_remain == setc) n.sda_oe_n = drv;
					if (t_zero) begin
						n.scl_oe_n = 1'b1;
						n.st       = ST_HIGH;
					end
				end
				ST_HIGH: if (!lines[1]) begin
					stretch = 1'b1;
				end else if (t_zero) begin
					lost = r.sda_oe_n & !lines[0] & (r.ack_only | (!r.rx & (r.bitn != 4'd8)));
					n.scl_oe_n = lost;
					if (lost) begin
						n.arb      = 1'b1;
						n.write_done_flag      = n.write_done_flag | !r.rx;
						n.st       = ST_IDLE;
						n.sda_oe_n = 1'b1;
						n.ack_only = 1'b0;
						n.lstate   = LS_BUSY;
					end else if (r.bitn == 4'd8 && r.ack_only) begin
						n.ack_only = 1'b0;
						n          = launch(n, r.post);
					end else if (r.bitn == 4'd8) begin
						n.last_received_acknowledge   = lines[0];
						n.rx      = r.addr_ph ? r.addr[0] : r.rx;
						n.addr_ph = 1'b0;
						if (r.addr_ph & r.addr[0] & !lines[0] & !r.setup[B_QUICK]) begin
							n.bitn = 4'd0;
							n.st   = ST_LOW;
						end else begin
							if (r.addr_ph & r.addr[0] & !lines[0]) n.read_done_flag = 1'b1;
							else n.write_done_flag = 1'b1;
							n.st   = ST_HOLD;
							n.hold = 1'b1;
						end
					end else if (r.rx && r.bitn == 4'd7) begin
						n.data = {r.sh[6:0], lines[0]};
						n.read_done_flag  = 1'b1;
						n.st   = ST_HOLD;
						n.hold = 1'b1;
					end else begin
						n.sh   = {r.sh[6:0], lines[0]};
						n.bitn = r.bitn + 4'd1;
						n.st   = ST_LOW;
					end
				end
				ST_HOLD: begin
				end
				ST_RS1: if (t_zero) begin
					n.scl_oe_n = 1'b1;
					n.st       = ST_RS2;
				end
				ST_RS2: if (!lines[1]) begin
					stretch = 1'b1;
				end else if (t_zero) begin
					n.sda_oe_n = 1'b0;
					n.st       = ST_START;
				end
				ST_SP1: if (t_zero) begin
					n.scl_oe_n = 1'b1;
					n.st       = ST_SP2;
				end
				ST_SP2: if (!lines[1]) begin
					stretch = 1'b1;
				end else if (t_zero) begin
					n.sda_oe_n = 1'b1;
					n.st       = ST_SP3;
				end
				ST_SP3: if (t_zero) begin
					n.st     = ST_IDLE;
					n.lstate = LS_IDLE;
				end
			endcase

			// foreign start or stop in the middle of our byte
			if ((st_det | sp_det) && (r.st == ST_LOW || r.st == ST_HIGH)) begin
				n.berr     = 1'b1;
				n.write_done_flag      = n.write_done_flag | !r.rx;
				n.st       = ST_IDLE;
				n.scl_oe_n = 1'b1;
				n.sda_oe_n = 1'b1;
				n.ack_only = 1'b0;
				n.lstate   = sp_det ? LS_IDLE : LS_BUSY;
			end
		end

		if (r.setup[B_ENABLE] && !r.flush && r.lstate != LS_OWNER) begin
			if (st_det) n.lstate = LS_BUSY;
			else if (sp_det) n.lstate = LS_IDLE;
			else if (to_zero && r.lstate == LS_BUSY && r.setup[B_TMO_LSB +: 2] != 2'h0) begin
				n.lstate = LS_IDLE;
			end
		end

		tload = stretch | (n.st != r.st) | (n.bitn != r.bitn);
		tval  = (n.st == ST_LOW) ? low_len : half;
		// any line movement restarts the quiet-bus timer
		to_load = (r.lstate != LS_BUSY) | (lines != r.prev);
		unique case (r.setup[B_TMO_LSB +: 2])
			2'h0: to_val = '0;
			2'h1: to_val = P_TMO1_CYC;
			2'h2: to_val = P_TMO2_CYC;
			2'h3: to_val = P_TMO3_CYC;
		endcase
		n.read_irq  = r.setup[B_RD_IEN] & r.read_done_flag & global_irq_enable;
		n.write_irq = r.setup[B_WR_IEN] & r.write_done_flag & global_irq_enable;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r          <= '0;
			r.line_ctl <= RST_LINE;
			r.setup    <= RST_SETUP;
			r.st       <= ST_IDLE;
			r.prev     <= 2'h3;
			r.scl_oe_n <= 1'b1;
			r.sda_oe_n <= 1'b1;
		end else if (ce) begin
			r <= n;
		end
	end

	assign prdata    = r.prdata;
	assign pready    = r.pready;
	assign pslverr   = r.pslverr;
	assign scl_out   = r.pin_lvl;
	assign scl_oe_n  = r.scl_oe_n;
	assign sda_out   = r.pin_lvl;
	assign sda_oe_n  = r.sda_oe_n;
	assign read_irq  = r.read_irq;
	assign write_irq = r.write_irq;
endmodule

// ==== verif/twic_host_monitor.sv ====
// assertion checker on the host controller ports
`timescale 1ns/1ps
module twic_host_monitor
	import twic_pkg::*;
(
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	// context and pins
	input wire logic        debug_halt,
	input wire logic        global_irq_enable,
	input wire logic        scl_oe_n,
	input wire logic        sda_oe_n,
	input wire logic        read_irq
);
	logic          wr, wc, rc, en, run, fast, lng, rde, sdq;
	logic [TW-1:0] sdc, loc, hic, half, setup;
	assign wr = psel && penable && pready && pwrite;
	assign wc = wr && paddr[11:2] == IDX_CMD;
	assign rc = psel && penable && pready && !pwrite && paddr[11:2] == IDX_CMD;
	assign half = fast ? FMP_HALF_CYC : STD_HALF_CYC;
	assign setup = lng ? SETUP_LONG_CYC : SETUP_SHORT_CYC;
	// saturating, so long holds never wrap into a short count
	function automatic logic [TW-1:0] inc(input logic [TW-1:0] c);
		return (&c) ? c : c + TW'(1);
	endfunction
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{en, run, fast, lng, rde} <= '0;
			sdq <= 1'h1;
			sdc <= '0;
			loc <= '0;
			hic <= '0;
		end else begin
			if (wr && paddr[11:2] == IDX_SETUP) begin
				en <= pwdata[B_ENABLE];
				rde <= pwdata[B_RD_IEN];
			end
			if (wr && paddr[11:2] == IDX_LINE) begin
				fast <= pwdata[B_FAST_PLUS];
				lng <= pwdata[B_SETUP_SEL];
			end
			if (wr && paddr[11:2] == IDX_DEBUG)
				run <= pwdata[B_DBG_RUN];
			sdq <= sda_oe_n;
			sdc <= (sda_oe_n != sdq) ? TW'(1) : inc(sdc);
			loc <= scl_oe_n ? '0 : inc(loc);
			hic <= scl_oe_n ? inc(hic) : '0;
		end
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_read_irq_gate: assert property (read_irq |-> $past(global_irq_enable) && $past(rde))
		else $error("read irq without enables");
	a_halt_freeze: assert property (debug_halt && !run |=> $stable(scl_oe_n) && $stable(sda_oe_n))
		else $error("pins moved while halted");
	a_off_released: assert property (!en && !$past(en) |-> scl_oe_n && sda_oe_n)
		else $error("pins driven while disabled");
	a_flush_release: assert property (wc && pwdata[B_FLUSH] |-> ##[1:4] scl_oe_n && sda_oe_n)
		else $error("flush left pins driven");
	a_cmd_reads_zero: assert property (rc |-> prdata[1:0] == 2'h0 && !prdata[B_FLUSH])
		else $error("strobe bits read nonzero");
	a_data_setup: assert property ($rose(scl_oe_n) |-> sdc >= setup)
		else $error("data setup too short");
	a_low_phase: assert property ($rose(scl_oe_n) |-> loc >= half)
		else $error("clock low too short");
	a_high_phase: assert property ($fell(scl_oe_n) |-> hic >= half)
		else $error("clock high too short");
	c_read_irq: cover property ($rose(read_irq));
	c_halted: cover property (debug_halt && !run && en);
	c_flush: cover property (wc && pwdata[B_FLUSH]);
endmodule
bind twic_host twic_host_monitor i_twic_host_monitor (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .debug_halt, .global_irq_enable, .scl_oe_n, .sda_oe_n,
	.read_irq);

// ==== verif/twic_target.sv ====
// behavioural bus target: acks every address and written byte, answers reads with tx
`timescale 1ns/1ps
module twic_target (
	// bus lines
	input  wire logic       scl,
	input  wire logic       sda,
	output logic            pull_n,
	// data
	input  wire logic [7:0] tx,
	output logic      [7:0] got
);
	logic [3:0] n = '0;
	logic       adr = 1'h0;
	logic       rd = 1'h0;
	logic [7:0] sh = '0;
	initial pull_n = 1'h1;
	always @(negedge sda) if (scl) begin
		n = '0;
		adr = 1'h1;
		rd = 1'h0;
	end
	always @(posedge sda) if (scl) begin
		n = '0;
		rd = 1'h0;
		pull_n = 1'h1;
	end
	always @(posedge scl) begin
		if (n < 8) sh = {sh[6:0], sda};
		// a host nack ends our sending
		if (n == 8 && !adr && rd && sda) rd = 1'h0;
		n = n + 4'h1;
	end
	always @(negedge scl) begin
		if (n == 8) begin
			if (adr) rd = sh[0];
			else if (!rd) got = sh;
			pull_n = rd && !adr;
		end else if (n == 9) begin
			n = '0;
			adr = 1'h0;
			pull_n = !rd | tx[7];
		end else if (rd && !adr) pull_n = tx[7-n];
	end
endmodule

// ==== verif/test_twic_host.sv ====
// self-checking bench for the two-wire host controller
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_fail++; $display("unexpected at %0t: got %h want %h", $time, (a), (e)); end end
module test_twic_host;
	import twic_pkg::*;
	logic        pclk = 1'h0;
	logic        presetn = 1'h0;
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic        dbg = 1'h0;
	logic        gie = 1'h0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic        pready, pslverr, err, scl_out, scl_oe_n, sda_out, sda_oe_n, pull_n, rirq, wirq;
	logic [7:0]  q, a, d, tx, got;
	logic [9:0]  idx [7] = '{IDX_LINE, IDX_DEBUG, IDX_SETUP, IDX_CMD, IDX_FLAGS, IDX_ADDR, IDX_DATA};
	int          n_fail = 0;
	int          check_count = 0;
	int          cyc = 0;
	wire         scl = scl_oe_n | scl_out;
	wire         sda = (sda_oe_n | sda_out) & pull_n;
	always #12.5 pclk = ~pclk;
	twic_host #(.P_TMO1_CYC(14'h0014), .P_TMO2_CYC(14'h0028), .P_TMO3_CYC(14'h0050)) i_twic_host (
		.pclk, .presetn, .ce(1'h1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .debug_halt(dbg), .global_irq_enable(gie), .scl_in(scl), .scl_out,
		.scl_oe_n, .sda_in(sda), .sda_out, .sda_oe_n, .read_irq(rirq), .write_irq(wirq));
	twic_target i_twic_target (.scl, .sda, .pull_n, .tx, .got);
	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 60000) begin
			n_fail++;
			report_and_stop();
		end
	end
	// starts one edge later, so back-to-back calls never drive psel twice in one step
	task automatic apb(input logic w, input logic [9:0] i, input logic [7:0] v);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {i, 2'h0};
		pwdata <= {24'h0, v};
		@(posedge pclk);
		penable <= 1'h1;
		// only the bench timeout ends a wait for the answer
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		q = prdata[7:0];
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wait_flag(input logic [7:0] m);
		q = '0;
		for (int k = 0; k < 4000 && (q & m) == 8'h00; k++)
			apb(1'h0, IDX_FLAGS, 8'h00);
	endtask
	task automatic tend(input string s);
		$display("%s done, %0d checks", s, check_count);
	endtask
	initial begin
		d = 8'($urandom(32'h0797));
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		foreach (idx[j]) begin
			apb(1'h0, idx[j], 8'h00);
			`CHK({err, q}, 9'h000)
		end
		apb(1'h0, 10'h006, 8'h00);
		`CHK(err, 1'h1)
		for (int j = 0; j < 4; j++) begin
			d = 8'($urandom);
			apb(1'h1, IDX_LINE, d);
			apb(1'h0, IDX_LINE, 8'h00);
			`CHK(q, d & LINE_MASK)
		end
		apb(1'h1, IDX_CMD, 8'h04);
		apb(1'h0, IDX_CMD, 8'h00);
		`CHK(q, 8'h04)
		tend("registers");
		apb(1'h1, IDX_SETUP, 8'hc1);
		apb(1'h1, IDX_ADDR, 8'h20);
		apb(1'h0, IDX_FLAGS, 8'h00);
		`CHK(q, 8'h44)
		`CHK(wirq, 1'h0)
		gie <= 1'h1;
		apb(1'h0, IDX_FLAGS, 8'h00);
		`CHK(wirq, 1'h1)
		apb(1'h1, IDX_FLAGS, 8'h01);
		tend("line state");
		d = 8'($urandom);
		apb(1'h1, IDX_LINE, (d & LINE_MASK) | 8'h02);
		a = 8'($urandom) & 8'hfe;
		apb(1'h1, IDX_ADDR, a);
		wait_flag(8'h40);
		`CHK(q, 8'h62)
		d = 8'($urandom);
		apb(1'h1, IDX_DATA, d);
		wait_flag(8'h40);
		`CHK(q, 8'h62)
		`CHK(got, d)
		apb(1'h1, IDX_CMD, 8'h03);
		wait_flag(8'h01);
		`CHK(q, 8'h01)
		tend("write");
		tx = 8'($urandom);
		apb(1'h1, IDX_ADDR, a | 8'h01);
		repeat (150) @(posedge pclk);
		dbg <= 1'h1;
		repeat (100) @(posedge pclk);
		dbg <= 1'h0;
		apb(1'h1, IDX_DEBUG, 8'h01);
		dbg <= 1'h1;
		wait_flag(8'h80);
		`CHK(q, 8'ha2)
		`CHK(rirq, 1'h1)
		apb(1'h0, IDX_DATA, 8'h00);
		`CHK(q, tx)
		tx = 8'($urandom);
		apb(1'h1, IDX_CMD, 8'h02);
		wait_flag(8'h80);
		apb(1'h0, IDX_DATA, 8'h00);
		`CHK(q, tx)
		apb(1'h1, IDX_CMD, 8'h05);
		wait_flag(8'hc0);
		apb(1'h1, IDX_CMD, 8'h07);
		wait_flag(8'h01);
		`CHK(q[1:0], 2'h1)
		apb(1'h0, IDX_CMD, 8'h00);
		`CHK(q, 8'h04)
		dbg <= 1'h0;
		tend("read");
		apb(1'h1, IDX_DATA, 8'($urandom));
		apb(1'h1, IDX_CMD, 8'h08);
		apb(1'h0, IDX_ADDR, 8'h00);
		`CHK(q, 8'h00)
		apb(1'h0, IDX_DATA, 8'h00);
		`CHK(q, 8'h00)
		apb(1'h0, IDX_FLAGS, 8'h00);
		`CHK(q[1:0], 2'h0)
		apb(1'h1, IDX_SETUP, 8'h00);
		apb(1'h1, IDX_FLAGS, 8'h01);
		apb(1'h0, IDX_FLAGS, 8'h00);
		`CHK(q[1:0], 2'h0)
		tend("flush and disable");
		report_and_stop();
	end
endmodule
